// ==== design/rdp_packer.sv ====
// Result data input packer: builds the cyclic input image
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
module rdp_packer (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                srst,
   // Wishbone slave
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [3:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic      [31:0]         wb_dat_o,
   output logic                     wb_ack_o,
   output logic                     irq,
   // Result source
   input  wire logic                resStart,
   input  wire rdp_pkg::rdp_hdr_t   resHdr,
   input  wire rdp_pkg::rdp_byte_t  resByte,
   input  wire logic                resDone,
   // Control and buffer state
   input  wire logic                moreResults,
   input  wire logic                bufFull,
   input  wire logic                waitAck,
   // Image read port for the fieldbus side
   input  wire logic [7:0]          imgIdx,
   output logic      [7:0]          imgByte,
   output logic      [7:0]          imgSize
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0]  stage [rdp_pkg::WIDE_BYTES];   // Fill buffer
   logic [7:0]  shown [rdp_pkg::WIDE_BYTES];   // Presented data field
   logic [31:0] ctrl;                          // Control register
   logic [rdp_pkg::EV_W-1:0] irqMask;          // Interrupt mask
   logic [rdp_pkg::EV_W-1:0] irqStat;          // Sticky events
   logic [rdp_pkg::EV_W-1:0] evSet;            // Event pulses
   logic [rdp_pkg::EV_W-1:0] evClr;            // Write-one clears
   rdp_pkg::rdp_state_t state;                 // Fill state
   logic [15:0] fillCnt;                       // Bytes received
   logic [15:0] curLen;                        // Length of filling result
   logic        curCmd;                        // Kind of filling result
   logic [15:0] imgLen;                        // Presented length
   logic        imgCmd;                        // Presented kind
   logic        toggle;                        // New result toggle
   logic [7:0]  statByte;                      // Live status byte
   logic [7:0]  fieldW;                        // Configured field width
   logic        wbReq;                         // New bus request
   logic        bufFullD;                      // Previous overflow level
   logic        commit;                        // Result is presented now
   logic [7:0]  dataIdx;                       // Index into data field

   // ----------------------------------------
   // Configuration
   // ----------------------------------------
   // Field width from control; wide selects 128 bytes
   always_comb
   begin
      if (ctrl[rdp_pkg::CTRL_WIDE])
      begin
         fieldW = 8'(rdp_pkg::WIDE_BYTES);
      end
      else
      begin
         fieldW = 8'(rdp_pkg::NARROW_BYTES);
      end
   end

   // Request seen once per bus cycle
   assign wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign commit = (state == rdp_pkg::FILL) & resDone;

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   // Ack one cycle after the request, dropped the next cycle
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= wbReq;
      end
   end

   // Control and mask writes with byte lane 0
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl    <= rdp_pkg::RST_WORD;
         irqMask <= '0;
      end
      else if (wbReq & wb_we_i & wb_sel_i[0])
      begin
         // Only the low control bits are implemented
         if (wb_adr_i == rdp_pkg::REG_CTRL)
         begin
            ctrl <= {30'h0000_0000, wb_dat_i[1:0]};
         end
         else if (wb_adr_i == rdp_pkg::REG_IRQMSK)
         begin
            irqMask <= wb_dat_i[rdp_pkg::EV_W-1:0];
         end
      end
   end

   // Read data; unmapped addresses read zero
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wb_dat_o <= rdp_pkg::RST_WORD;
      end
      else if (wbReq & ~wb_we_i)
      begin
         unique case (wb_adr_i)
            rdp_pkg::REG_CTRL:   wb_dat_o <= ctrl;
            // Header as shown in the image
            rdp_pkg::REG_STATUS: wb_dat_o <= {8'h00, imgLen, statByte};
            rdp_pkg::REG_IRQST:  wb_dat_o <= {29'h0000_0000, irqStat};
            rdp_pkg::REG_IRQMSK: wb_dat_o <= {29'h0000_0000, irqMask};
            default:             wb_dat_o <= rdp_pkg::RST_WORD;
         endcase
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   // Event pulses from presentation and overflow edge
   always_comb
   begin
      evSet = '0;
      evSet[rdp_pkg::EV_NEW]   = commit;
      evSet[rdp_pkg::EV_TRUNC] = commit & (curLen > 16'(fieldW));
      evSet[rdp_pkg::EV_OVFL]  = bufFull & ~bufFullD;
      evClr = '0;
      if (wbReq & wb_we_i & wb_sel_i[0] & (wb_adr_i == rdp_pkg::REG_IRQST))
      begin
         evClr = wb_dat_i[rdp_pkg::EV_W-1:0];
      end
   end

   // Sticky status bits
   rdp_sticky #(
      .W (rdp_pkg::EV_W)
   ) u_sticky (
      .clk  (clk),
      .srst (srst),
      .set  (evSet),
      .clr  (evClr),
      .q    (irqStat)
   );

   // Level interrupt and overflow edge memory
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         irq      <= 1'b0;
         bufFullD <= 1'b0;
      end
      else
      begin
         irq      <= |(irqStat & irqMask);
         bufFullD <= bufFull;
      end
   end

   // ----------------------------------------
   // Result fill
   // ----------------------------------------
   // Start clears buffer; bytes past the field are dropped
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state   <= rdp_pkg::IDLE;
         fillCnt <= 16'h0000;
         curLen  <= 16'h0000;
         curCmd  <= 1'b0;
         for (int i = 0; i < rdp_pkg::WIDE_BYTES; i++)
         begin
            stage[i] <= 8'h00;
         end
      end
      else if (resStart)
      begin
         state   <= rdp_pkg::FILL;
         fillCnt <= 16'h0000;
         curLen  <= resHdr.len;
         curCmd  <= resHdr.isCmd;
         for (int i = 0; i < rdp_pkg::WIDE_BYTES; i++)
         begin
            stage[i] <= 8'h00;
         end
      end
      else
      begin
         unique case (state)
            rdp_pkg::IDLE:
            begin
               state <= rdp_pkg::IDLE;
            end
            rdp_pkg::FILL:
            begin
               // Keep only bytes inside length and field width
               if (resByte.valid & (fillCnt < curLen))
               begin
                  if (fillCnt < 16'(fieldW))
                  begin
                     stage[fillCnt[6:0]] <= resByte.data;
                  end
                  fillCnt <= fillCnt + 16'h0001;
               end
               if (resDone)
               begin
                  state <= rdp_pkg::IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Presented image
   // ----------------------------------------
   // Copy the finished result and flip the toggle
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         imgLen <= 16'h0000;
         imgCmd <= 1'b0;
         toggle <= 1'b0;
         for (int i = 0; i < rdp_pkg::WIDE_BYTES; i++)
         begin
            shown[i] <= 8'h00;
         end
      end
      else if (commit)
      begin
         imgLen <= curLen;
         imgCmd <= curCmd;
         toggle <= ~toggle;
         for (int i = 0; i < rdp_pkg::WIDE_BYTES; i++)
         begin
            shown[i] <= stage[i];
         end
      end
   end

   // Live status byte, reserved bits zero
   always_comb
   begin
      statByte = 8'h00;
      statByte[rdp_pkg::ST_ACTIVE]  = ctrl[rdp_pkg::CTRL_ACT];
      statByte[rdp_pkg::ST_CMDRESP] = imgCmd;
      statByte[rdp_pkg::ST_MORE]    = moreResults;
      statByte[rdp_pkg::ST_OVFL]    = bufFull;
      statByte[rdp_pkg::ST_TOGGLE]  = toggle;
      statByte[rdp_pkg::ST_WAITACK] = waitAck;
   end

   assign dataIdx = imgIdx - 8'(rdp_pkg::HDR_BYTES);

   // ----------------------------------------
   // Image read port
   // ----------------------------------------
   // Byte at index, header first; beyond the field reads zero
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         imgByte <= 8'h00;
         imgSize <= 8'h00;
      end
      else
      begin
         imgSize <= fieldW + 8'(rdp_pkg::HDR_BYTES);
         if (imgIdx == rdp_pkg::STAT_IDX)
         begin
            imgByte <= statByte;
         end
         else if (imgIdx == rdp_pkg::LEN_MSB_IDX)
         begin
            imgByte <= imgLen[15:8];
         end
         else if (imgIdx == rdp_pkg::LEN_LSB_IDX)
         begin
            imgByte <= imgLen[7:0];
         end
         else if (dataIdx < fieldW)
         begin
            imgByte <= shown[dataIdx[6:0]];
         end
         else
         begin
            imgByte <= 8'h00;
         end
      end
   end
endmodule

// ==== design/rdp_pkg.sv ====
// Package of constants and types for the result data input packer
package rdp_pkg;
   // ----------------------------------------
   // Image layout
   // ----------------------------------------
   localparam int unsigned HDR_BYTES    = 3;    // Status plus 16-bit length
   localparam int unsigned NARROW_BYTES = 96;   // Narrow data field width
   localparam int unsigned WIDE_BYTES   = 128;  // Wide data field width
   localparam int unsigned IDX_W        = 8;    // Image byte index width
   localparam logic [7:0]  LEN_MSB_IDX  = 8'h01; // Length high byte index
   localparam logic [7:0]  LEN_LSB_IDX  = 8'h02; // Length low byte index
   localparam logic [7:0]  STAT_IDX     = 8'h00; // Status byte index
   // ----------------------------------------
   // Status byte bit positions
   // ----------------------------------------
   localparam int unsigned ST_ACTIVE  = 0;  // Activation state
   localparam int unsigned ST_CMDRESP = 2;  // Reply from command interpreter
   localparam int unsigned ST_MORE    = 3;  // More results buffered
   localparam int unsigned ST_OVFL    = 4;  // Buffer full, discarding
   localparam int unsigned ST_TOGGLE  = 5;  // New result toggle
   localparam int unsigned ST_WAITACK = 7;  // Waiting for acknowledgment
   // ----------------------------------------
   // Wishbone register map
   // ----------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0; // Control
   localparam logic [3:0] REG_STATUS = 4'h4; // Image header view
   localparam logic [3:0] REG_IRQST  = 4'h8; // Sticky events, write 1 clear
   localparam logic [3:0] REG_IRQMSK = 4'hC; // Interrupt mask
   localparam int unsigned CTRL_ACT  = 0;    // Control: activate
   localparam int unsigned CTRL_WIDE = 1;    // Control: 128-byte field
   localparam int unsigned EV_W      = 3;    // Number of events
   localparam int unsigned EV_NEW    = 0;    // Event: new result shown
   localparam int unsigned EV_TRUNC  = 1;    // Event: result truncated
   localparam int unsigned EV_OVFL   = 2;    // Event: buffer overflow rose
   localparam logic [31:0] RST_WORD  = 32'h0000_0000; // Reset value
   // ----------------------------------------
   // Carrier types
   // ----------------------------------------
   typedef struct packed
   {
      logic [15:0] len;    // Original result length
      logic        isCmd;  // Reply from command interpreter
   } rdp_hdr_t;
   typedef struct packed
   {
      logic [7:0] data;    // One result byte
      logic       valid;   // Byte present
   } rdp_byte_t;
   typedef enum logic [1:0] {IDLE, FILL} rdp_state_t;
endpackage

// ==== design/rdp_sticky.sv ====
// Sticky event bits, set wins over a write-one clear
module rdp_sticky #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // Events and clears
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   // Sticky state
   output logic      [W-1:0] q
);
   // Hold each bit until cleared; a set in the clear cycle survives
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         q <= '0;
      end
      else
      begin
         q <= (q & ~clr) | set;
      end
   end
endmodule

// ==== tb/rdp_props.sv ====
// Port checks for the result data input packer
module rdp_props (
   // Clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // Bus and interrupt
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       irq,
   // Result and levels
   input wire logic       resDone,
   input wire logic       moreResults,
   input wire logic       bufFull,
   input wire logic       waitAck,
   // Image port
   input wire logic [7:0] imgIdx,
   input wire logic [7:0] imgByte,
   input wire logic [7:0] imgSize
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ---------
   // Sequences
   // ---------
   // Request not yet answered
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // Header read with steady flag inputs
   sequence s_flags;
      (imgIdx == 8'h00 && $stable({moreResults, bufFull}))[*3];
   endsequence
   // ---------
   // Checks
   // ---------
   a_ack_follows: assert property (s_req |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_reset_clear: assert property ($past(srst) |-> !irq && !wb_ack_o
      && imgSize == 8'h00 && imgByte == 8'h00)
      else $error("outputs not cleared by reset");
   a_size_legal: assert property (imgSize inside {8'h00, 8'h63, 8'h83})
      else $error("image size illegal");
   a_reserved_zero: assert property (imgIdx == 8'h00 |=>
      imgByte[1] == 1'b0 && imgByte[6] == 1'b0)
      else $error("reserved status bit set");
   a_flag_bits: assert property (s_flags |=>
      imgByte[4:3] == $past({bufFull, moreResults}))
      else $error("buffer flags wrong");
   a_wait_bit: assert property ((imgIdx == 8'h00
      && $stable(waitAck))[*3] |=> imgByte[7] == $past(waitAck))
      else $error("wait bit wrong");
   a_toggle_cause: assert property ($past(imgIdx) == 8'h00
      && $past(imgIdx, 2) == 8'h00 && $changed(imgByte[5])
      |-> $past(resDone, 2) || $past(resDone, 3) || $past(resDone, 4))
      else $error("toggle moved without new result");
   a_beyond_zero: assert property (imgIdx > 8'h82 |=> imgByte == 8'h00)
      else $error("byte past image not zero");
endmodule

// ==== tb/rdp_reader.sv ====
// Fieldbus side model that scans the whole input image
module rdp_reader (
   // Clock and scan request
   input  wire logic       clk,
   input  wire logic       go,
   // Image read port
   input  wire logic [7:0] imgByte,
   output logic      [7:0] imgIdx,
   // Scan state
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] img [0:134]; // Captured bytes, past image end too
   logic [7:0] n = 8'h00;   // Scan step
   initial
   begin
      imgIdx = 8'h00;
      busy = 1'b0;
   end
   // Steps the index, stores each byte one cycle later
   always @(posedge clk)
   begin
      if (go && !busy)
      begin
         busy <= 1'b1;
         n <= 8'h01;
         imgIdx <= 8'h01;
      end
      else if (busy)
      begin
         img[n - 8'h01] <= imgByte;
         imgIdx <= (n == 8'h87) ? 8'h00 : n + 8'h01;
         busy <= (n != 8'h87);
         n <= n + 8'h01;
      end
   end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the result data input packer
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------
   // Signals
   // ---------
   logic               clk = 1'b0, srst = 1'b1;     // Clock, reset
   logic               cyc = 1'b0, stb = 1'b0;      // Bus request
   logic               we = 1'b0;                   // Bus direction
   logic [3:0]         adr = 4'h0, sel = 4'hF;      // Address, lanes
   logic [31:0]        dout = '0, din, rd;          // Bus data
   logic               ack, irq;                    // Answer, interrupt
   logic               start = 1'b0, done = 1'b0;   // Result framing
   rdp_pkg::rdp_hdr_t  hdr = '0;                    // Result header
   rdp_pkg::rdp_byte_t bytIn = '0;                  // Result byte
   logic               more = 1'b0, full = 1'b0;    // Buffer levels
   logic               waitAck = 1'b0;              // Waiting level
   logic [7:0]         imgIdx, imgByte, imgSize;    // Image port
   logic               go = 1'b0, busy;             // Scan control
   int                 fails = 0, nCompared = 0;    // Counters
   rdp_packer rdp_packer_i (.clk(clk), .srst(srst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dout), .wb_dat_o(din), .wb_ack_o(ack), .irq(irq),
      .resStart(start), .resHdr(hdr), .resByte(bytIn), .resDone(done),
      .moreResults(more), .bufFull(full), .waitAck(waitAck),
      .imgIdx(imgIdx), .imgByte(imgByte), .imgSize(imgSize));
   rdp_reader rdp_reader_i (.clk(clk), .go(go), .imgByte(imgByte),
      .imgIdx(imgIdx), .busy(busy));
   always #2.5 clk = ~clk;
   // ---------
   // Tasks
   // ---------
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] s, e);
      nCompared++;
      if (s !== e)
      begin
         fails++;
         $display("[ERR] %s exp %h saw %h", nm, e, s);
      end
   endtask
   // Verdict and end of run
   task automatic wrap_up;
      if (fails == 0 && nCompared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // One classic cycle, read data left in rd
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
      int t;
      t = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dout <= d;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (ack !== 1'b1 && t < 50);
      if (t >= 50)
         fails++;
      rd = din;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   // One result of len bytes, byte k is k+11h
   task automatic send(input logic [15:0] len, input logic cmd);
      start <= 1'b1;
      hdr <= '{len: len, isCmd: cmd};
      for (int i = 0; i < len; i++)
      begin
         @(posedge clk);
         start <= 1'b0;
         bytIn <= '{data: 8'(i + 8'h11), valid: 1'b1};
      end
      @(posedge clk);
      bytIn.valid <= 1'b0;
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // Full scan compared with the expected image
   task automatic img_chk(input logic [7:0] st, input logic [15:0] len,
                          input int fw);
      logic [7:0] e;
      int t;
      t = 0;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (busy === 1'b1 && t < 200);
      chk("imgSize", 32'(imgSize), 32'(fw + 3));
      for (int i = 0; i < 135; i++)
      begin
         e = (i >= 3 && i < fw + 3 && i - 3 < len) ? 8'(i + 14) : 8'h00;
         if (i < 3)
            e = (i == 0) ? st : (i == 1) ? len[15:8] : len[7:0];
         chk("imgByte", 32'(rdp_reader_i.img[i]), 32'(e));
      end
   endtask
   // ---------
   // Scenarios
   // ---------
   // Reset image, register defaults, unmapped read
   task automatic t_reset;
      wb(1'b0, rdp_pkg::REG_CTRL, '0);
      chk("ctrl", rd, rdp_pkg::RST_WORD);
      wb(1'b0, rdp_pkg::REG_IRQMSK, '0);
      chk("mask", rd, rdp_pkg::RST_WORD);
      wb(1'b0, 4'h2, '0);
      chk("unmapped", rd, 32'h0000_0000);
      // Write without byte lane 0 must not reach control
      sel <= 4'hE;
      wb(1'b1, rdp_pkg::REG_CTRL, 32'h0000_0003);
      sel <= 4'hF;
      wb(1'b0, rdp_pkg::REG_CTRL, '0);
      chk("ctrl lane", rd, rdp_pkg::RST_WORD);
      img_chk(8'h00, 16'h0000, 96);
   endtask
   // Narrow short result, flags, interrupt clear
   task automatic t_narrow;
      more <= 1'b1;
      waitAck <= 1'b1;
      wb(1'b1, rdp_pkg::REG_CTRL, 32'h0000_0001);
      wb(1'b1, rdp_pkg::REG_IRQMSK, 32'h0000_0001);
      send(16'h0005, 1'b0);
      chk("irq", 32'(irq), 32'h0000_0001);
      wb(1'b0, rdp_pkg::REG_STATUS, '0);
      chk("status", rd, 32'h0000_05A9);
      img_chk(8'hA9, 16'h0005, 96);
      wb(1'b1, rdp_pkg::REG_IRQST, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk("irq", 32'(irq), 32'h0000_0000);
   endtask
   // Wide oversized reply, truncation and masking
   task automatic t_wide;
      more <= 1'b0;
      waitAck <= 1'b0;
      full <= 1'b1;
      wb(1'b1, rdp_pkg::REG_CTRL, 32'h0000_0003);
      send(16'h00C8, 1'b1);
      img_chk(8'h15, 16'h00C8, 128);
      wb(1'b0, rdp_pkg::REG_IRQST, '0);
      chk("irqst", rd, 32'h0000_0007);
      chk("irq", 32'(irq), 32'h0000_0001);
      wb(1'b1, rdp_pkg::REG_IRQMSK, '0);
      repeat (2) @(posedge clk);
      chk("irq", 32'(irq), 32'h0000_0000);
      // Short result after a long one: old bytes must read zero
      send(16'h0004, 1'b0);
      img_chk(8'h31, 16'h0004, 128);
   endtask
   // Mid-run reset clears a filled image and the registers
   task automatic t_rerun;
      full <= 1'b0;
      srst <= 1'b1;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk("irq", 32'(irq), 32'h0000_0000);
      wb(1'b0, rdp_pkg::REG_CTRL, '0);
      chk("ctrl", rd, rdp_pkg::RST_WORD);
      img_chk(8'h00, 16'h0000, 96);
   endtask
   // ---------
   // Main and watchdog
   // ---------
   initial
   begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_narrow;
      t_wide;
      t_rerun;
      wrap_up;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      wrap_up;
   end
endmodule
bind rdp_packer rdp_props rdp_props_i (.clk, .srst, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .irq, .resDone, .moreResults, .bufFull,
   .waitAck, .imgIdx, .imgByte, .imgSize);
